// File: rtl/spd_eeprom_write_protect_ctrl.sv
// write side of a two-wire serial eeprom slave: write framing, page buffer,
// block protection, page select and busy lockout
// assumes scl/sda/straps arrive asynchronously and the array signals done
`include "wp_ctrl_map.svh"

module spd_eeprom_write_protect_ctrl
   import wp_ctrl_pkg::*;
(
   input  logic      clk_in,
   input  logic      reset_n_in,
   input  logic      scl_in,
   input  logic      sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   input  logic      strap_zero_in,
   input  logic      strap_one_in,
   input  logic      strap_two_in,
   input  logic      elevated_voltage_in,
   input  logic      prog_done_in,
   output logic      prog_start_out,
   output prog_req_t prog_req_out,
   output logic      busy_out,
   output logic [3:0] protect_out,
   output logic      page_out
);

   // ****************************************
   // helpers
   // ****************************************

   function automatic logic [4:0] popcount(input logic [15:0] m);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 16; i++) begin
         n = n + {4'h0, m[i]};
      end
      return n;
   endfunction

   // straps compared only for memory access, commands reach every device
   function automatic sel_t sel_decode(input logic [7:0] b, input logic [2:0] sa);
      sel_t s;
      s.kind = K_NONE;
      s.blk  = 2'h0;
      if (b[7:4] == `DT_MEM && b[3:1] == sa) begin
         s.kind = b[0] ? K_MEMR : K_MEMW;
      end else if (b[7:4] == `DT_CMD) begin
         case (b[3:0])
            `SEL_SETP0: s = '{K_SETP, 2'h0};
            `SEL_SETP1: s = '{K_SETP, 2'h1};
            `SEL_SETP2: s = '{K_SETP, 2'h2};
            `SEL_SETP3: s = '{K_SETP, 2'h3};
            `SEL_CLR:   s = '{K_CLR,  2'h0};
            `SEL_QRYP0: s = '{K_QRYP, 2'h0};
            `SEL_QRYP1: s = '{K_QRYP, 2'h1};
            `SEL_QRYP2: s = '{K_QRYP, 2'h2};
            `SEL_QRYP3: s = '{K_QRYP, 2'h3};
            `SEL_SETH0: s = '{K_SETH, 2'h0};
            `SEL_SETH1: s = '{K_SETH, 2'h1};
            `SEL_QRYH:  s = '{K_QRYH, 2'h0};
            default:    s = '{K_NONE, 2'h0};
         endcase
      end
      return s;
   endfunction

   // ****************************************
   // pin synchronisers and filters
   // ****************************************

   logic [5:0] s1_q, s2_q, s3_q, filt_q;
   logic       scl_p_q, sda_p_q;

   // three stages; value moves only once stages two and three agree
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1_q    <= 6'h03;
         s2_q    <= 6'h03;
         s3_q    <= 6'h03;
         filt_q  <= 6'h03;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         s1_q    <= {elevated_voltage_in, strap_two_in, strap_one_in,
                     strap_zero_in, sda_in, scl_in};
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         filt_q  <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
         scl_p_q <= filt_q[0];
         sda_p_q <= filt_q[1];
      end
   end

   logic       scl_w, sda_w, hv_w;
   logic [2:0] strap_w;
   logic       scl_rise_w, scl_fall_w, sta_w, sto_w;

   // bus conditions found from filtered levels
   assign scl_w      = filt_q[0];
   assign sda_w      = filt_q[1];
   assign strap_w    = filt_q[4:2];
   assign hv_w       = filt_q[5];
   assign scl_rise_w = scl_w & ~scl_p_q;
   assign scl_fall_w = ~scl_w & scl_p_q;
   assign sta_w      = scl_w & scl_p_q & sda_p_q & ~sda_w;
   assign sto_w      = scl_w & scl_p_q & ~sda_p_q & sda_w;

   // ****************************************
   // byte engine and decode
   // ****************************************

   state_t     st_q;
   cmd_t       kind_q;
   logic [1:0] blk_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, addr_q, base_q;
   logic       ack_q, acked_q, got_q, busy_q, page_q, oe_q;
   logic [3:0] prot_q;
   logic [15:0] mask_q;
   logic [7:0] buf_q [16];

   logic [7:0] byte_w;
   sel_t       sel_w;
   logic       last_rise_w, prot_sel_w, sel_ack_w, sel_go_w;
   logic       hit_w, data_ack_w, byte_ack_w, commit_w;

   // select decision; busy hides the device entirely
   assign byte_w      = {sh_q[6:0], sda_w};
   assign last_rise_w = scl_rise_w & (cnt_q == `BIT_LAST) & (st_q != ST_IDLE);
   assign sel_w       = sel_decode(byte_w, strap_w);
   assign prot_sel_w  = prot_q[sel_w.blk];
   assign sel_ack_w   = ~busy_q & (
      (sel_w.kind == K_MEMW) | (sel_w.kind == K_MEMR) | (sel_w.kind == K_SETH) |
      ((sel_w.kind == K_SETP) & hv_w & ~prot_sel_w) |
      ((sel_w.kind == K_CLR) & hv_w) |
      ((sel_w.kind == K_QRYP) & ~prot_sel_w) |
      ((sel_w.kind == K_QRYH) & ~page_q));
   assign sel_go_w    = sel_ack_w & ((sel_w.kind == K_MEMW) | (sel_w.kind == K_SETP) |
                        (sel_w.kind == K_CLR) | (sel_w.kind == K_SETH));
   assign hit_w       = prot_q[{page_q, addr_q[7]}];
   assign data_ack_w  = (kind_q != K_MEMW) | ~hit_w;
   assign byte_ack_w  = (st_q == ST_SEL)  ? sel_ack_w :
                        (st_q == ST_ADDR) ? 1'b1 :
                        (st_q == ST_DATA) ? data_ack_w : 1'b0;
   assign commit_w    = sto_w & (st_q == ST_DATA) & acked_q & got_q & ~busy_q;

   // bit counter and ack record; a start restarts the frame
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         ack_q   <= 1'b0;
         acked_q <= 1'b0;
      end else if (sta_w) begin
         cnt_q   <= 4'h0;
         ack_q   <= 1'b0;
         acked_q <= 1'b0;
      end else if (scl_rise_w) begin
         cnt_q   <= (cnt_q == `BIT_ACK) ? 4'h0 : cnt_q + 4'h1;
         sh_q    <= byte_w;
         ack_q   <= last_rise_w ? byte_ack_w : ack_q;
         // the clock rise that leads into a stop must not lose the ack record
         acked_q <= (cnt_q == `BIT_ACK) ? ack_q : (acked_q & (cnt_q == 4'h0));
      end
   end

   // open-drain ack: pull low from the fall after bit 8 to the next fall
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         oe_q <= 1'b0;
      end else if (sta_w | sto_w) begin
         oe_q <= 1'b0;
      end else if (scl_fall_w) begin
         oe_q <= (cnt_q == `BIT_ACK) & ack_q;
      end
   end

   // frame state machine
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= ST_IDLE;
         kind_q <= K_NONE;
         blk_q  <= 2'h0;
      end else if (sta_w) begin
         st_q <= ST_SEL;
      end else if (sto_w) begin
         st_q <= ST_IDLE;
      end else if (last_rise_w) begin
         unique case (st_q)
            ST_SEL: begin
               st_q   <= sel_go_w ? ST_ADDR : ST_SKIP;
               kind_q <= sel_w.kind;
               blk_q  <= sel_w.blk;
            end
            ST_ADDR: st_q <= ST_DATA;
            ST_DATA: st_q <= data_ack_w ? ST_DATA : ST_SKIP;
            ST_SKIP: st_q <= ST_SKIP;
            default: st_q <= ST_SKIP;
         endcase
      end
   end

   // ****************************************
   // page buffer and word address
   // ****************************************

   // whole page held in flops so a stop can hand it over in one go
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         addr_q <= 8'h00;
         base_q <= 8'h00;
         mask_q <= 16'h0000;
         got_q  <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (sta_w) begin
         mask_q <= 16'h0000;
         got_q  <= 1'b0;
      end else if (last_rise_w && st_q == ST_ADDR && kind_q == K_MEMW) begin
         addr_q <= byte_w;
         base_q <= byte_w;
      end else if (last_rise_w && st_q == ST_DATA && data_ack_w) begin
         got_q <= 1'b1;
         if (kind_q == K_MEMW) begin
            buf_q[addr_q[3:0]]  <= byte_w;
            mask_q[addr_q[3:0]] <= 1'b1;
            addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
         end
      end
   end

   // ****************************************
   // protection, page and program cycle
   // ****************************************

   logic      pstart_q;
   prog_req_t prog_q;
   logic [127:0] flat_w;

   always_comb begin
      flat_w = '0;
      for (int i = 0; i < 16; i++) begin
         flat_w[i*8 +: 8] = buf_q[i];
      end
   end

   // protect bits change only when the cycle launches at stop
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prot_q <= `PROT_RST;
         page_q <= `PAGE_RST;
      end else if (commit_w && kind_q == K_SETP) begin
         prot_q[blk_q] <= 1'b1;
      end else if (commit_w && kind_q == K_CLR) begin
         prot_q <= 4'h0;
      end else if (last_rise_w && st_q == ST_SEL && sel_w.kind == K_SETH && sel_ack_w) begin
         page_q <= sel_w.blk[0];
      end
   end

   // page-set commands are volatile and start no program cycle
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_q   <= 1'b0;
         pstart_q <= 1'b0;
         prog_q   <= '0;
      end else begin
         pstart_q <= 1'b0;
         if (commit_w && kind_q != K_SETH) begin
            busy_q   <= 1'b1;
            pstart_q <= 1'b1;
            prog_q   <= '{kind_q == K_MEMW, page_q, base_q, popcount(mask_q),
                          mask_q, flat_w};
         end else if (prog_done_in) begin
            busy_q <= 1'b0;
         end
      end
   end

   assign sda_out        = 1'b0;
   assign sda_oe_out     = oe_q;
   assign prog_start_out = pstart_q;
   assign prog_req_out   = prog_q;
   assign busy_out       = busy_q;
   assign protect_out    = prot_q;
   assign page_out       = page_q;

   // ****************************************
   // assertions
   // ****************************************

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_busy_quiet;
      busy_q |-> !oe_q;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");

   property p_commit_cause;
      pstart_q |-> $past(sto_w) && $past(acked_q) && $past(got_q);
   endproperty
   a_commit_cause: assert property (p_commit_cause) else $error("bad launch");

   property p_count;
      pstart_q && prog_q.mem |-> prog_q.count == popcount(prog_q.mask) && prog_q.count != 5'h00;
   endproperty
   a_count: assert property (p_count) else $error("byte count wrong");

   property p_qryh;
      last_rise_w && st_q == ST_SEL && sel_w.kind == K_QRYH && !busy_q |=> ack_q == !page_q;
   endproperty
   a_qryh: assert property (p_qryh) else $error("half query ack wrong");

   property p_qryp;
      last_rise_w && st_q == ST_SEL && sel_w.kind == K_QRYP && !busy_q
         |=> ack_q == !prot_q[$past(sel_w.blk)];
   endproperty
   a_qryp: assert property (p_qryp) else $error("protect query ack wrong");

   property p_prot_data;
      last_rise_w && st_q == ST_DATA && kind_q == K_MEMW && hit_w
         |=> !ack_q && st_q == ST_SKIP;
   endproperty
   a_prot_data: assert property (p_prot_data) else $error("protected data acked");

   property p_nibble;
      st_q == ST_DATA && $past(st_q) == ST_DATA |-> addr_q[7:4] == $past(addr_q[7:4]);
   endproperty
   a_nibble: assert property (p_nibble) else $error("high nibble moved");

   property p_clr;
      commit_w && kind_q == K_CLR |=> prot_q == 4'h0 && busy_q;
   endproperty
   a_clr: assert property (p_clr) else $error("clear-all failed");

   property p_setp;
      commit_w && kind_q == K_SETP |=> prot_q == ($past(prot_q) | (4'h1 << $past(blk_q)));
   endproperty
   a_setp: assert property (p_setp) else $error("set protect wrong");

   property p_hv;
      last_rise_w && st_q == ST_SEL && !hv_w &&
         (sel_w.kind == K_SETP || sel_w.kind == K_CLR) |=> !ack_q;
   endproperty
   a_hv: assert property (p_hv) else $error("acked without high voltage");

   property p_ack_drive;
      scl_fall_w && cnt_q == `BIT_ACK && ack_q && !sta_w && !sto_w |=> oe_q;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

endmodule // spd_eeprom_write_protect_ctrl

// File: rtl/wp_ctrl_map.svh
// constants for the serial eeprom write and protect command logic
// assumes inclusion by the package user only, no processes here
`ifndef WP_CTRL_MAP_SVH
`define WP_CTRL_MAP_SVH
// device type field of the select byte
`define DT_MEM    4'hA
`define DT_CMD    4'h6
// low select nibble of the command type, a whole command code with the direction in its last bit
`define SEL_SETP0 4'h2
`define SEL_SETP1 4'h8
`define SEL_SETP2 4'hA
`define SEL_SETP3 4'h0
`define SEL_CLR   4'h6
`define SEL_QRYP0 4'h3
`define SEL_QRYP1 4'h9
`define SEL_QRYP2 4'hB
`define SEL_QRYP3 4'h1
`define SEL_SETH0 4'hC
`define SEL_SETH1 4'hE
`define SEL_QRYH  4'hD
// reset values
`define PAGE_RST  1'b0
`define PROT_RST  4'h0
// bit counter marks
`define BIT_LAST  4'h7
`define BIT_ACK   4'h8
`endif

// File: rtl/wp_ctrl_pkg.sv
// types for the serial eeprom write and protect command logic
// assumes nothing beyond a systemverilog compiler
package wp_ctrl_pkg;
   typedef enum logic [2:0] {
      K_NONE = 3'b000, K_MEMW = 3'b001, K_MEMR = 3'b010, K_SETP = 3'b011,
      K_CLR  = 3'b100, K_QRYP = 3'b101, K_SETH = 3'b110, K_QRYH = 3'b111
   } cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_SEL = 3'b001, ST_ADDR = 3'b010, ST_DATA = 3'b011,
      ST_SKIP = 3'b100
   } state_t;
   typedef struct packed {
      cmd_t       kind;
      logic [1:0] blk;
   } sel_t;
   typedef struct packed {
      logic         mem;
      logic         page;
      logic [7:0]   addr;
      logic [4:0]   count;
      logic [15:0]  mask;
      logic [127:0] data;
   } prog_req_t;
endpackage

// File: dv/i2c_master_model.sv
// two-wire bus master model driving the eeprom command logic
// assumes the bench resolves the open-drain data wire and feeds it back
// ****************************************
// master model
// ****************************************
module i2c_master_model (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int half = 8;   // 40 ns of 5 ns clocks, 80 ns link period
   // bus idles released, pull-ups hold both lines high
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // start from idle; clock stands still between frames
   task automatic start_c();
      sda_out <= 1'b0;
      tick(half);
      scl_out <= 1'b0;
      tick(half / 2);
   endtask
   // msb first, data changes only while the clock is low
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_out <= b[i];
         tick(half / 2);
         scl_out <= 1'b1;
         tick(half);
         scl_out <= 1'b0;
         tick(half / 2);
      end
      sda_out <= 1'b1;
      tick(half / 2);
      scl_out <= 1'b1;
      tick(half / 2);
      ack = ~sda_in;
      tick(half / 2);
      scl_out <= 1'b0;
      tick(half / 2);
   endtask
   task automatic stop_c();
      sda_out <= 1'b0;
      tick(half / 2);
      scl_out <= 1'b1;
      tick(half);
      sda_out <= 1'b1;
      tick(half);
   endtask
endmodule // i2c_master_model

// File: dv/test_spd_eeprom_write_protect_ctrl.sv
// self-checking bench for the eeprom write and protect command logic
// assumes the master model above and a 200 MHz system clock
// ****************************************
// bench top
// ****************************************
module test_spd_eeprom_write_protect_ctrl;
   import wp_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {prog_req_t r; logic [3:0] prot;} note_t;
   localparam logic [3:0] set_code [4] = '{4'h2, 4'h8, 4'hA, 4'h0};
   logic       clk_in, reset_n_in, scl_w, m_sda, sda_w, sda_out, sda_oe_out;
   logic       strap_zero_in, strap_one_in, strap_two_in, elevated_voltage_in;
   logic       prog_done_in, prog_start_out, busy_out, page_out;
   logic [3:0] protect_out, exp_prot;
   prog_req_t  prog_req_out;
   note_t      exp_q[$];
   logic [7:0] tx [0:19];
   logic [2:0] sa;
   int         errors, tests_run, seed;
   // open-drain wire: low when either party pulls
   assign sda_w = m_sda & (sda_oe_out ? sda_out : 1'b1);
   spd_eeprom_write_protect_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .strap_zero_in(strap_zero_in), .strap_one_in(strap_one_in),
      .strap_two_in(strap_two_in), .elevated_voltage_in(elevated_voltage_in),
      .prog_done_in(prog_done_in), .prog_start_out(prog_start_out),
      .prog_req_out(prog_req_out), .busy_out(busy_out), .protect_out(protect_out),
      .page_out(page_out));
   i2c_master_model i_master (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w),
      .sda_out(m_sda));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic cmp_val(input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_req(input prog_req_t e, input prog_req_t g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic summarize();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watcher: every launch must match the oldest note in mem flag and protect bits, memory writes in full
   initial begin : watch
      note_t     n;
      prog_req_t g;
      forever begin
         @(negedge clk_in);
         if (prog_start_out === 1'b1) begin
            cmp_val(1'b1, busy_out);
            if (exp_q.size() == 0) begin
               errors++;
               $display("FAIL t=%0t exp=%h got=%h", $time, 1'b0, prog_start_out);
            end else begin
               n = exp_q.pop_front();
               g = prog_req_out;
               // bytes outside the mask are stale buffer contents, not part of the cycle
               for (int i = 0; i < 16; i++) begin
                  if (!g.mask[i]) begin
                     g.data[8 * i +: 8] = 8'h00;
                  end
               end
               if (n.r.mem) cmp_req(n.r, g);
               else cmp_val(n.r.mem, prog_req_out.mem);
               cmp_val(n.prot, protect_out);
            end
         end
      end
   end
   // array model: program cycle ends a fixed time after launch
   initial begin
      forever begin
         @(posedge clk_in);
         if (prog_start_out === 1'b1) begin
            repeat (300) @(posedge clk_in);
            prog_done_in <= 1'b1;
            @(posedge clk_in);
            prog_done_in <= 1'b0;
         end
      end
   end
   task automatic frame(input int n, input logic [19:0] ea);
      logic a;
      i_master.start_c();
      for (int i = 0; i < n; i++) begin
         i_master.put_byte(tx[i], a);
         cmp_val(ea[i], a);
      end
      i_master.stop_c();
      repeat (16) @(posedge clk_in);   // room for a stray launch to show
   endtask
   // poll with read direction, stop right after the ack
   task automatic poll();
      logic a;
      int   k;
      k = 0;
      a = 1'b0;
      while (a !== 1'b1 && k < 40) begin
         i_master.start_c();
         i_master.put_byte({4'hA, sa, 1'b1}, a);
         i_master.stop_c();
         k++;
      end
      cmp_val(1'b1, k > 1);
      cmp_val(1'b0, busy_out);
      if (k >= 40) begin
         errors++;
         summarize();
      end
   endtask
   task automatic mwrite(input logic pg, input logic [7:0] ad, input int nd, input logic ok);
      note_t      e;
      logic [3:0] idx;
      e = '0;
      tx[0] = {4'hA, sa, 1'b0};
      tx[1] = ad;
      e.r.mem = 1'b1;
      e.r.page = pg;
      e.r.addr = ad;
      e.r.count = (nd > 16) ? 5'd16 : 5'(nd);
      e.prot = exp_prot;
      for (int i = 0; i < nd; i++) begin
         tx[i + 2] = $random(seed);
         idx = ad[3:0] + 4'(i);   // low nibble wraps inside the page
         e.r.data[8 * idx +: 8] = tx[i + 2];
         e.r.mask[idx] = 1'b1;
      end
      if (ok) exp_q.push_back(e);
      frame(nd + 2, ok ? 20'hFFFFF : 20'h00003);
      if (ok) poll();
   endtask
   task automatic cmd(input logic [3:0] code, input logic hv, input int n,
                      input logic [19:0] ea, input logic prog);
      note_t e;
      e = '0;
      e.prot = exp_prot;
      tx[0] = {4'h6, code};
      tx[1] = $random(seed);
      tx[2] = $random(seed);
      elevated_voltage_in <= hv;
      @(posedge clk_in);
      if (prog) exp_q.push_back(e);
      frame(n, ea);
      if (prog) poll();
      elevated_voltage_in <= 1'b0;
      @(posedge clk_in);
   endtask
   // main sequence
   initial begin
      seed = 32'h6715;
      errors = 0;
      tests_run = 0;
      exp_prot = 4'h0;
      reset_n_in = 1'b0;
      prog_done_in = 1'b0;
      elevated_voltage_in = 1'b0;
      sa = 3'($random(seed));
      {strap_two_in, strap_one_in, strap_zero_in} = sa;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      cmp_val(1'b0, page_out);
      cmp_val(4'h0, protect_out);
      $display("test reset done");
      mwrite(1'b0, 8'($random(seed)), 1, 1'b1);
      mwrite(1'b0, 8'($random(seed)), 18, 1'b1);
      mwrite(1'b0, 8'hFA, 9, 1'b1);
      tx[0] = {4'hA, ~sa, 1'b0};
      frame(3, 20'h0);
      tx[0] = {4'hA, sa, 1'b0};
      frame(2, 20'h3);
      $display("test write done");
      cmd(set_code[1], 1'b0, 3, 20'h0, 1'b0);
      exp_prot = 4'b0010;
      cmd(set_code[1], 1'b1, 3, 20'h7, 1'b1);
      mwrite(1'b0, 8'h7F, 1, 1'b1);
      mwrite(1'b0, 8'h80, 1, 1'b0);
      cmd(4'hE, 1'b0, 3, 20'h7, 1'b0);
      cmp_val(1'b1, page_out);
      cmd(4'hD, 1'b0, 1, 20'h0, 1'b0);
      mwrite(1'b1, 8'h80, 1, 1'b1);
      cmd(4'hC, 1'b0, 3, 20'h7, 1'b0);
      cmd(4'hD, 1'b0, 1, 20'h1, 1'b0);
      $display("test page done");
      for (int n = 0; n < 4; n++) begin
         cmd(set_code[n] | 4'h1, 1'b0, 1, {19'h0, ~exp_prot[n]}, 1'b0);
         if (n == 1) begin
            cmd(set_code[n], 1'b1, 3, 20'h0, 1'b0);
         end else begin
            exp_prot[n] = 1'b1;
            cmd(set_code[n], 1'b1, 3, 20'h7, 1'b1);
         end
         cmd(set_code[n] | 4'h1, 1'b0, 1, 20'h0, 1'b0);
      end
      exp_prot = 4'h0;
      cmd(4'h6, 1'b1, 3, 20'h7, 1'b1);
      cmd(set_code[2] | 4'h1, 1'b0, 1, 20'h1, 1'b0);
      $display("test protect done");
      cmp_val(1'b1, exp_q.size() == 0);
      cmp_val(1'b0, sda_out);
      summarize();
   end
endmodule // test_spd_eeprom_write_protect_ctrl
